// ### verilog/pccr_regs.vh
// register map, field positions, reset values and frame codes
// of the control and configuration register bank.
// assumes inclusion by bare name from the design files.
`ifndef PCCR_REGS_VH
`define PCCR_REGS_VH

// register addresses on the management interface
`define PCCR_ADDR_EXT_CTRL 5'h11
`define PCCR_ADDR_CFG_ONE 5'h12

// extended_control field positions
`define PCCR_EC_LINK_EN 15
`define PCCR_EC_PWR_HI 14
`define PCCR_EC_PWR_LO 11
`define PCCR_EC_JITTER 10
`define PCCR_EC_TRAIN 9
`define PCCR_EC_TEST_HI 8
`define PCCR_EC_TEST_LO 6
`define PCCR_EC_CABLE 5
`define PCCR_EC_LOOP_HI 4
`define PCCR_EC_LOOP_LO 3
`define PCCR_EC_CFG_EN 2
`define PCCR_EC_SUPPLY 1
`define PCCR_EC_ROUSE 0

// configuration_one field positions
`define PCCR_C1_MASTER 15
`define PCCR_C1_SELF_RUN 14
`define PCCR_C1_HOST_HI 9
`define PCCR_C1_HOST_LO 8
`define PCCR_C1_PAD 7
`define PCCR_C1_REST 6
`define PCCR_C1_IND_HI 5
`define PCCR_C1_IND_LO 4
`define PCCR_C1_IND_ON 3

// reset values
`define PCCR_RST_PWR 4'h0
`define PCCR_RST_TEST 3'h0
`define PCCR_RST_LOOP 2'h0
`define PCCR_RST_SUPPLY 1'b1
`define PCCR_RST_IND 2'h1

// operating-state request codes
`define PCCR_PWR_NONE 4'h0
`define PCCR_PWR_NORMAL 4'h3
`define PCCR_PWR_STANDBY 4'hc
`define PCCR_PWR_SLEEP_REQ 4'hb

// test select codes
`define PCCR_TEST_NONE 3'h0
`define PCCR_TEST_LAST_PHY 3'h5
`define PCCR_TEST_BYPASS 3'h6

// indicator sources
`define PCCR_IND_LINK 2'h0
`define PCCR_IND_RX 2'h1
`define PCCR_IND_SYMERR 2'h2
`define PCCR_IND_CRS 2'h3

// management frame fields
`define PCCR_OP_READ 2'h2
`define PCCR_OP_WRITE 2'h1
`define PCCR_HDR_LAST 5'h0b
`define PCCR_DATA_LAST 5'h0f

`endif

// ### verilog/pccr_sync3.v
// three-stage input synchroniser with agreement filter.
// assumes inputs from outside the core clock domain; no reset,
// so the output is valid three edges after the pin settles.
`timescale 1ns/10ps
`default_nettype none
module pccr_sync3 #(
	parameter W = 1
) (
	input wire core_clk_in,
	input wire [W-1:0] async_in,
	output reg [W-1:0] stable_out
);
	reg [W-1:0] stage1;
	reg [W-1:0] stage2;
	reg [W-1:0] stage3;
	reg [W-1:0] held;

	// three-stage chain and the last agreed value
	always @(posedge core_clk_in) begin
		stage1 <= async_in;
		stage2 <= stage1;
		stage3 <= stage2;
		held <= stable_out;
	end

	// follows stage three where stage two agrees, else holds;
	// no extra flop, so straps are valid by the fourth reset edge
	always @* begin
		stable_out = (~(stage2 ^ stage3) & stage3) |
			((stage2 ^ stage3) & held);
	end
endmodule
`default_nettype wire

// ### verilog/pccr_bank.v
// management-reachable control and configuration register bank
// with its serial management slave.
// assumes mdc/mdio and straps are asynchronous pins; status and
// launch inputs come from logic on core_clk_in.
// Rules from the document
// R1: link-management enable resets to the self-run select value.
// R2: state request 0000/0011/1100/1011 decoded; other codes raise bad-command.
// R3: bit 10 enables follower jitter test; resets to 0.
// R4: training rerun written 1 restarts training, self-clears; 0 halts.
// R5: test select: none, modes 1-5, scrambler bypass, 111 reserved.
// R6: cable test written 1 starts, self-clears; written 0 stops.
// R7: configuration register writes only accepted while gate bit 2 is 1.
// R8: bit 1 keeps supply switch on in Disable mode; resets to 1.
// R9: rouse bit 1 sends idle symbols as wake request; resets 0.
// R10: manager clears link enable before setting rouse request; not enforced, a write sets rouse whatever link enable holds.
// R11: configuration bit 15 selects master (1) or slave (0).
// R12: host interface select: MII, RMII refclk, RMII crystal, reverse MII.
// R13: bit 7 selects standard (0) or reduced (1) pad strength.
// R14: bit 6 requires partner confirmation before sleep; default 0.
// R15: indicator source: link good, frame rx, symbol error, carrier; default 01.
// R16: bit 3 gives shared pin to indicator output or wake input.
// R17: clearing link enable returns latched link status bits to defaults.
// R18: self-clearing bits read 1 until their action is launched.
`timescale 1ns/10ps
`default_nettype none
`include "pccr_regs.vh"
module pccr_bank (
	input wire core_clk_in,
	input wire srst_in,
	input wire mdc_in,
	input wire mdio_in,
	output reg mdio_out,
	output reg mdio_oe_out,
	input wire [4:0] phy_address_in,
	input wire strap_master_in,
	input wire strap_self_run_in,
	input wire [1:0] strap_host_if_in,
	input wire wake_pin_in,
	input wire link_good_in,
	input wire frame_rx_active_in,
	input wire symbol_error_in,
	input wire carrier_sense_in,
	input wire training_launched_in,
	input wire cable_test_launched_in,
	output reg link_enable_out,
	output reg [3:0] state_request_out,
	output reg state_request_valid_out,
	output reg bad_command_out,
	output reg jitter_test_out,
	output reg training_rerun_out,
	output reg training_halt_out,
	output reg [2:0] phy_test_mode_out,
	output reg scrambler_bypass_out,
	output reg cable_test_out,
	output reg cable_test_stop_out,
	output reg [1:0] loopback_mode_out,
	output reg supply_switch_setting_out,
	output reg bus_rouse_out,
	output reg link_status_clear_out,
	output reg master_role_out,
	output reg self_run_select_out,
	output reg [1:0] host_if_select_out,
	output reg reduced_pad_out,
	output reg rest_handshake_required_out,
	output reg [1:0] indicator_source_out,
	output reg indicator_output_on_out,
	output wire indicator_pin_out,
	output wire indicator_pin_oe_out,
	output wire local_wake_out
);
	localparam ST_IDLE = 3'h0;
	localparam ST_START = 3'h1;
	localparam ST_HDR = 3'h2;
	localparam ST_TA1 = 3'h3;
	localparam ST_TA2 = 3'h4;
	localparam ST_DATA = 3'h5;

	wire mdc_s;
	wire mdio_s;
	wire wake_s;
	wire [3:0] strap_s;
	reg mdc_d;
	reg [2:0] state;
	reg [4:0] cnt;
	reg [15:0] shift;
	reg [11:0] hdr;
	reg [1:0] cur_op;
	reg [4:0] cur_reg;
	reg for_us;
	reg [3:0] pwr_field;
	reg cfg_gate;
	reg ind_q;
	reg [15:0] rd_data;
	wire mdc_rise;
	wire [15:0] wr_data;
	wire do_write;
	reg [2:0] phy_test_mode_sel;
	// pin synchronisers
	pccr_sync3 #(.W(3)) u_sync_pins (
		.core_clk_in(core_clk_in),
		.async_in({mdc_in, mdio_in, wake_pin_in}),
		.stable_out({mdc_s, mdio_s, wake_s})
	);
	pccr_sync3 #(.W(4)) u_sync_straps (
		.core_clk_in(core_clk_in),
		.async_in({strap_master_in, strap_self_run_in, strap_host_if_in}),
		.stable_out(strap_s)
	);
	// operating-state code check
	function pccr_pwr_ok;
		input [3:0] code;
		begin
			pccr_pwr_ok = (code == `PCCR_PWR_NONE) ||
				(code == `PCCR_PWR_NORMAL) ||
				(code == `PCCR_PWR_STANDBY) ||
				(code == `PCCR_PWR_SLEEP_REQ);
		end
	endfunction
	// indicator source selection
	function pccr_ind_pick;
		input [1:0] sel;
		input a;
		input b;
		input c;
		input d;
		begin
			case (sel)
			`PCCR_IND_LINK: pccr_ind_pick = a;
			`PCCR_IND_RX: pccr_ind_pick = b;
			`PCCR_IND_SYMERR: pccr_ind_pick = c;
			default: pccr_ind_pick = d;
			endcase
		end
	endfunction
	assign mdc_rise = mdc_s & ~mdc_d;
	assign wr_data = {shift[14:0], mdio_s};
	assign do_write = mdc_rise && (state == ST_DATA) &&
		(cnt == `PCCR_DATA_LAST) && for_us && (cur_op == `PCCR_OP_WRITE);
	// read-back mux; unmapped addresses read zero
	always @* begin
		rd_data = 16'h0000;
		case (cur_reg)
		`PCCR_ADDR_EXT_CTRL: begin
			rd_data[`PCCR_EC_LINK_EN] = link_enable_out;
			rd_data[`PCCR_EC_PWR_HI:`PCCR_EC_PWR_LO] = pwr_field;
			rd_data[`PCCR_EC_JITTER] = jitter_test_out;
			rd_data[`PCCR_EC_TRAIN] = training_rerun_out; // [R18]
			rd_data[`PCCR_EC_TEST_HI:`PCCR_EC_TEST_LO] = phy_test_mode_sel;
			rd_data[`PCCR_EC_CABLE] = cable_test_out; // [R18]
			rd_data[`PCCR_EC_LOOP_HI:`PCCR_EC_LOOP_LO] = loopback_mode_out;
			rd_data[`PCCR_EC_CFG_EN] = cfg_gate;
			rd_data[`PCCR_EC_SUPPLY] = supply_switch_setting_out;
			rd_data[`PCCR_EC_ROUSE] = bus_rouse_out;
		end
		`PCCR_ADDR_CFG_ONE: begin
			rd_data[`PCCR_C1_MASTER] = master_role_out;
			rd_data[`PCCR_C1_SELF_RUN] = self_run_select_out;
			rd_data[`PCCR_C1_HOST_HI:`PCCR_C1_HOST_LO] = host_if_select_out;
			rd_data[`PCCR_C1_PAD] = reduced_pad_out;
			rd_data[`PCCR_C1_REST] = rest_handshake_required_out;
			rd_data[`PCCR_C1_IND_HI:`PCCR_C1_IND_LO] = indicator_source_out;
			rd_data[`PCCR_C1_IND_ON] = indicator_output_on_out;
		end
		default: rd_data = 16'h0000;
		endcase
	end
	// management frame engine, sampling mdio on mdc rising edges
	always @(posedge core_clk_in) begin
		if (srst_in) begin
			mdc_d <= 1'b1;
			state <= ST_IDLE;
			cnt <= 5'h00;
			shift <= 16'h0000;
			hdr <= 12'h000;
			cur_op <= 2'h0;
			cur_reg <= 5'h00;
			for_us <= 1'b0;
			mdio_out <= 1'b0;
			mdio_oe_out <= 1'b0;
		end else begin
			mdc_d <= mdc_s;
			if (mdc_rise) begin
				case (state)
				ST_IDLE: begin
					if (!mdio_s)
						state <= ST_START;
				end
				ST_START: begin
					state <= mdio_s ? ST_HDR : ST_IDLE;
					cnt <= 5'h00;
				end
				ST_HDR: begin
					hdr <= {hdr[10:0], mdio_s};
					cnt <= cnt + 5'h01;
					if (cnt == `PCCR_HDR_LAST) begin
						cur_op <= hdr[10:9];
						cur_reg <= {hdr[3:0], mdio_s};
						for_us <= (hdr[8:4] == phy_address_in) &&
							((hdr[10:9] == `PCCR_OP_READ) ||
							(hdr[10:9] == `PCCR_OP_WRITE));
						state <= ST_TA1;
					end
				end
				ST_TA1: begin
					// turnaround: drive zero in the second bit of a read
					if (for_us && cur_op == `PCCR_OP_READ) begin
						mdio_oe_out <= 1'b1;
						mdio_out <= 1'b0;
					end
					state <= ST_TA2;
				end
				ST_TA2: begin
					shift <= rd_data;
					mdio_out <= rd_data[15];
					cnt <= 5'h00;
					state <= ST_DATA;
				end
				ST_DATA: begin
					shift <= wr_data;
					mdio_out <= shift[14];
					cnt <= cnt + 5'h01;
					if (cnt == `PCCR_DATA_LAST) begin
						mdio_oe_out <= 1'b0;
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
				endcase
			end
		end
	end
	// extended_control register
	always @(posedge core_clk_in) begin
		if (srst_in) begin
			link_enable_out <= strap_s[2]; // [R1]
			pwr_field <= `PCCR_RST_PWR;
			jitter_test_out <= 1'b0;
			training_rerun_out <= 1'b0;
			phy_test_mode_sel <= `PCCR_RST_TEST;
			cable_test_out <= 1'b0;
			loopback_mode_out <= `PCCR_RST_LOOP;
			cfg_gate <= 1'b0; // [R7]
			supply_switch_setting_out <= `PCCR_RST_SUPPLY; // [R8]
			bus_rouse_out <= 1'b0;
			state_request_out <= `PCCR_RST_PWR;
			state_request_valid_out <= 1'b0;
			bad_command_out <= 1'b0;
			training_halt_out <= 1'b0;
			cable_test_stop_out <= 1'b0;
			link_status_clear_out <= 1'b0;
		end else begin
			state_request_valid_out <= 1'b0;
			bad_command_out <= 1'b0;
			training_halt_out <= 1'b0;
			cable_test_stop_out <= 1'b0;
			link_status_clear_out <= 1'b0;
			// self-clear once launched; a new write of 1 wins
			if (training_launched_in)
				training_rerun_out <= 1'b0; // [R4] [R18]
			if (cable_test_launched_in)
				cable_test_out <= 1'b0; // [R6] [R18]
			if (do_write && cur_reg == `PCCR_ADDR_EXT_CTRL) begin
				link_enable_out <= wr_data[`PCCR_EC_LINK_EN];
				// latched status back to default on disable
				link_status_clear_out <= link_enable_out &
					~wr_data[`PCCR_EC_LINK_EN]; // [R17]
				if (pccr_pwr_ok(wr_data[`PCCR_EC_PWR_HI:`PCCR_EC_PWR_LO])) begin
					pwr_field <= wr_data[`PCCR_EC_PWR_HI:`PCCR_EC_PWR_LO];
					state_request_out <=
						wr_data[`PCCR_EC_PWR_HI:`PCCR_EC_PWR_LO]; // [R2]
					state_request_valid_out <=
						wr_data[`PCCR_EC_PWR_HI:`PCCR_EC_PWR_LO] !=
						`PCCR_PWR_NONE; // [R2]
				end else begin
					bad_command_out <= 1'b1; // [R2]
				end
				jitter_test_out <= wr_data[`PCCR_EC_JITTER]; // [R3]
				training_rerun_out <= wr_data[`PCCR_EC_TRAIN]; // [R4]
				training_halt_out <= ~wr_data[`PCCR_EC_TRAIN]; // [R4]
				phy_test_mode_sel <=
					wr_data[`PCCR_EC_TEST_HI:`PCCR_EC_TEST_LO];
				cable_test_out <= wr_data[`PCCR_EC_CABLE]; // [R6]
				cable_test_stop_out <= ~wr_data[`PCCR_EC_CABLE]; // [R6]
				loopback_mode_out <=
					wr_data[`PCCR_EC_LOOP_HI:`PCCR_EC_LOOP_LO];
				cfg_gate <= wr_data[`PCCR_EC_CFG_EN];
				supply_switch_setting_out <= wr_data[`PCCR_EC_SUPPLY]; // [R8]
				bus_rouse_out <= wr_data[`PCCR_EC_ROUSE]; // [R9]
			end
		end
	end
	// test select decode; reserved code selects nothing
	always @* begin
		phy_test_mode_out = `PCCR_TEST_NONE;
		scrambler_bypass_out = 1'b0;
		if (phy_test_mode_sel <= `PCCR_TEST_LAST_PHY)
			phy_test_mode_out = phy_test_mode_sel; // [R5]
		else if (phy_test_mode_sel == `PCCR_TEST_BYPASS)
			scrambler_bypass_out = 1'b1; // [R5]
	end
	// configuration_one register, writable only through the gate
	always @(posedge core_clk_in) begin
		if (srst_in) begin
			master_role_out <= strap_s[3];
			self_run_select_out <= strap_s[2];
			host_if_select_out <= strap_s[1:0];
			reduced_pad_out <= 1'b0;
			rest_handshake_required_out <= 1'b0;
			indicator_source_out <= `PCCR_RST_IND;
			indicator_output_on_out <= 1'b0;
		end else if (do_write && cur_reg == `PCCR_ADDR_CFG_ONE &&
			cfg_gate) begin // [R7]
			master_role_out <= wr_data[`PCCR_C1_MASTER]; // [R11]
			self_run_select_out <= wr_data[`PCCR_C1_SELF_RUN];
			host_if_select_out <=
				wr_data[`PCCR_C1_HOST_HI:`PCCR_C1_HOST_LO]; // [R12]
			reduced_pad_out <= wr_data[`PCCR_C1_PAD]; // [R13]
			rest_handshake_required_out <= wr_data[`PCCR_C1_REST]; // [R14]
			indicator_source_out <=
				wr_data[`PCCR_C1_IND_HI:`PCCR_C1_IND_LO]; // [R15]
			indicator_output_on_out <= wr_data[`PCCR_C1_IND_ON]; // [R16]
		end
	end
	// indicator level from the selected source
	always @(posedge core_clk_in) begin
		if (srst_in)
			ind_q <= 1'b0;
		else
			ind_q <= pccr_ind_pick(indicator_source_out, link_good_in,
				frame_rx_active_in, symbol_error_in,
				carrier_sense_in); // [R15]
	end
	// shared pin: indicator drive or wake input
	assign indicator_pin_out = ind_q;
	assign indicator_pin_oe_out = indicator_output_on_out; // [R16]
	assign local_wake_out = wake_s & ~indicator_output_on_out; // [R16]
endmodule
`default_nettype wire

// ### test/pccr_bank_sva.sv
// port assertions for the control and configuration bank.
// assumes one clock and the synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module pccr_bank_sva (
	input wire core_clk_in,
	input wire srst_in,
	input wire link_good_in,
	input wire frame_rx_active_in,
	input wire symbol_error_in,
	input wire carrier_sense_in,
	input wire training_launched_in,
	input wire link_enable_out,
	input wire [3:0] state_request_out,
	input wire state_request_valid_out,
	input wire bad_command_out,
	input wire training_rerun_out,
	input wire [2:0] phy_test_mode_out,
	input wire scrambler_bypass_out,
	input wire link_status_clear_out,
	input wire self_run_select_out,
	input wire [1:0] indicator_source_out,
	input wire indicator_output_on_out,
	input wire indicator_pin_out,
	input wire indicator_pin_oe_out,
	input wire local_wake_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (srst_in);
	// indicator sources in select order
	wire [3:0] src = {carrier_sense_in, symbol_error_in, frame_rx_active_in,
		link_good_in};
	property p_rst_link;
		$fell(srst_in) |-> link_enable_out == self_run_select_out;
	endproperty
	a_rst_link: assert property (p_rst_link) else $error("link reset");
	property p_bad;
		bad_command_out |-> !state_request_valid_out ##1 !bad_command_out;
	endproperty
	a_bad: assert property (p_bad) else $error("bad pulse");
	property p_req;
		state_request_valid_out |-> ##[0:1]
			state_request_out inside {4'h3, 4'hc, 4'hb};
	endproperty
	a_req: assert property (p_req) else $error("request code");
	property p_test;
		phy_test_mode_out <= 3'h5 &&
			!(scrambler_bypass_out && phy_test_mode_out != 3'h0);
	endproperty
	a_test: assert property (p_test) else $error("test decode");
	property p_train_sc;
		training_rerun_out && training_launched_in |=> !training_rerun_out;
	endproperty
	a_train_sc: assert property (p_train_sc) else $error("rerun");
	property p_oe;
		indicator_pin_oe_out == indicator_output_on_out;
	endproperty
	a_oe: assert property (p_oe) else $error("pin enable");
	property p_wake;
		local_wake_out |-> !indicator_output_on_out;
	endproperty
	a_wake: assert property (p_wake) else $error("wake gate");
	property p_pin;
		!$past(srst_in) |->
			indicator_pin_out == $past(src[indicator_source_out]);
	endproperty
	a_pin: assert property (p_pin) else $error("pin source");
	property p_lclr;
		link_status_clear_out |-> ##[0:1] !link_enable_out;
	endproperty
	a_lclr: assert property (p_lclr) else $error("status clear");
endmodule
bind pccr_bank pccr_bank_sva chk_u (.*);
`default_nettype wire

// ### test/pccr_mgr.sv
// station manager model: frames on mdc and mdio.
// assumes the bench resolves mdio with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module pccr_mgr (
	input wire logic core_clk_in,
	input wire logic mdio_line_in,
	output logic mdc_out,
	output logic mdio_out,
	output logic mdio_oe_out
);
	// idle: clock parked low, line released
	initial begin
		mdc_out = 1'b0;
		mdio_out = 1'b0;
		mdio_oe_out = 1'b0;
	end
	// one frame, each bit 8 cycles low then 8 high, no preamble
	task automatic xfer(input logic [1:0] op, input logic [4:0] pa,
		input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [31:0] f;
		f = {2'b01, op, pa, ra, 2'b10, wd};
		rd = 16'h0;
		for (int i = 31; i >= 0; i--) begin
			@(posedge core_clk_in);
			mdc_out <= 1'b0;
			mdio_out <= f[i];
			mdio_oe_out <= !(op == 2'h2 && i < 18); // release for answer
			repeat (8) @(posedge core_clk_in);
			rd = {rd[14:0], mdio_line_in};
			mdc_out <= 1'b1;
			repeat (7) @(posedge core_clk_in);
		end
		@(posedge core_clk_in);
		mdc_out <= 1'b0;
		mdio_oe_out <= 1'b0;
		repeat (8) @(posedge core_clk_in);
	endtask
endmodule
`default_nettype wire

// ### test/pccr_bank_test.sv
// self-checking bench of the control and configuration bank.
// assumes pccr_mgr as station manager on a pulled-up mdio line.
`timescale 1ns/10ps
`default_nettype none
`include "pccr_regs.vh"
module pccr_bank_test;
	logic core_clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic strap_master_in = 1'b1;
	logic strap_self_run_in = 1'b1;
	logic [1:0] strap_host_if_in = 2'h2;
	logic [4:0] phy_address_in = 5'h05;
	logic wake_pin_in = 1'b1;
	logic link_good_in = 1'b1;
	logic frame_rx_active_in = 1'b0;
	logic symbol_error_in = 1'b1;
	logic carrier_sense_in = 1'b0;
	logic training_launched_in = 1'b0;
	logic cable_test_launched_in = 1'b0;
	wire mdc_in, mdio_in, mdio_out, mdio_oe_out, m_d, m_oe;
	wire link_enable_out, state_request_valid_out, bad_command_out;
	wire jitter_test_out, training_rerun_out, training_halt_out;
	wire scrambler_bypass_out, cable_test_out, cable_test_stop_out;
	wire supply_switch_setting_out, bus_rouse_out, link_status_clear_out;
	wire master_role_out, self_run_select_out, reduced_pad_out;
	wire rest_handshake_required_out, indicator_output_on_out;
	wire indicator_pin_out, indicator_pin_oe_out, local_wake_out;
	wire [3:0] state_request_out;
	wire [2:0] phy_test_mode_out;
	wire [1:0] loopback_mode_out, host_if_select_out, indicator_source_out;
	wire [3:0] src = {carrier_sense_in, symbol_error_in, frame_rx_active_in,
		link_good_in};
	logic [15:0] rd, w;
	logic [3:0] ep = 4'h0;
	logic [2:0] k;
	logic [15:0] cv [4] = '{16'h3c07, 16'hfff8, 16'h4150, 16'h82a8};
	logic [3:0] pc [8] = '{4'h3, 4'hc, 4'hb, 4'h5, 4'h0, 4'hf, 4'h3, 4'h0};
	int bad_count = 0;
	int num_checks = 0;
	int n_req = 0;
	int n_bad = 0;
	int n_sc = 0;
	// pulled-up mdio line shared by both ends
	assign mdio_in = mdio_oe_out ? mdio_out : (m_oe ? m_d : 1'b1);
	pccr_bank dut_u (.*);
	pccr_mgr mgr_u (.core_clk_in(core_clk_in), .mdio_line_in(mdio_in),
		.mdc_out(mdc_in), .mdio_out(m_d), .mdio_oe_out(m_oe));
	// 20 MHz core clock
	always #25 core_clk_in = ~core_clk_in;
	// count one-cycle request, refusal, halt and stop pulses
	always @(posedge core_clk_in) begin
		if (state_request_valid_out === 1'b1)
			n_req++;
		if (bad_command_out === 1'b1)
			n_bad++;
		if (training_halt_out === 1'b1)
			n_sc++;
		if (cable_test_stop_out === 1'b1)
			n_sc++;
	end
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		mgr_u.xfer(`PCCR_OP_WRITE, phy_address_in, a, d, rd);
	endtask
	task automatic rdc(input logic [4:0] a, input logic [15:0] e,
		input string nm);
		mgr_u.xfer(`PCCR_OP_READ, phy_address_in, a, 16'h0, rd);
		chk(nm, rd, e);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// run-length limit
	initial begin
		#3000000;
		bad_count++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		repeat (4) @(posedge core_clk_in);
		srst_in <= 1'b0;
		rdc(`PCCR_ADDR_EXT_CTRL, 16'h8002, "ext reset");
		rdc(`PCCR_ADDR_CFG_ONE, 16'hc210, "cfg reset");
		wr(`PCCR_ADDR_CFG_ONE, 16'h0000);
		rdc(`PCCR_ADDR_CFG_ONE, 16'hc210, "cfg locked");
		wr(`PCCR_ADDR_EXT_CTRL, 16'h0004);
		foreach (cv[i]) begin
			wr(`PCCR_ADDR_CFG_ONE, cv[i]);
			rdc(`PCCR_ADDR_CFG_ONE, cv[i] & 16'hc3f8, "cfg word");
			chk("cfg ports", 16'({master_role_out, self_run_select_out,
				host_if_select_out, reduced_pad_out, rest_handshake_required_out,
				indicator_source_out, indicator_output_on_out}),
				16'({cv[i][15:14], cv[i][9:3]}));
			chk("pin", 16'({indicator_pin_out, indicator_pin_oe_out,
				local_wake_out}), 16'({src[cv[i][5:4]], cv[i][3], ~cv[i][3]}));
		end
		for (int i = 0; i < 8; i++) begin
			k = i[2:0];
			w = {1'b0, pc[i], k[0], 1'b0, k, 1'b0, k[1:0], 1'b1, ~k[0], 1'b0};
			if (pc[i] inside {4'h0, 4'h3, 4'hb, 4'hc})
				ep = pc[i];
			wr(`PCCR_ADDR_EXT_CTRL, w);
			rdc(`PCCR_ADDR_EXT_CTRL, {1'b0, ep, w[10:0]}, "ext word");
			chk("ext ports", 16'({jitter_test_out, phy_test_mode_out,
				scrambler_bypass_out, loopback_mode_out,
				supply_switch_setting_out}), 16'({k[0],
				((k <= 3'h5) ? k : 3'h0), k == 3'h6, k[1:0], ~k[0]}));
		end
		chk("requests", 16'(n_req), 16'h4);
		chk("refusals", 16'(n_bad), 16'h2);
		wr(`PCCR_ADDR_EXT_CTRL, 16'h0224);
		rdc(`PCCR_ADDR_EXT_CTRL, 16'h0224, "sc held");
		@(posedge core_clk_in) training_launched_in <= 1'b1;
		@(posedge core_clk_in) training_launched_in <= 1'b0;
		@(posedge core_clk_in) #1;
		chk("train", 16'({training_rerun_out, cable_test_out}), 16'h1);
		@(posedge core_clk_in) cable_test_launched_in <= 1'b1;
		@(posedge core_clk_in) cable_test_launched_in <= 1'b0;
		@(posedge core_clk_in) #1;
		chk("cable", 16'(cable_test_out), 16'h0);
		wr(`PCCR_ADDR_EXT_CTRL, 16'h0224);
		wr(`PCCR_ADDR_EXT_CTRL, 16'h0004);
		chk("sc off", 16'({training_rerun_out, cable_test_out}), 16'h0);
		wr(`PCCR_ADDR_EXT_CTRL, 16'h0005);
		chk("rouse", 16'(bus_rouse_out), 16'h1);
		wr(`PCCR_ADDR_EXT_CTRL, 16'h0004);
		chk("rouse off", 16'(bus_rouse_out), 16'h0);
		rdc(5'h13, 16'h0000, "unmapped");
		mgr_u.xfer(`PCCR_OP_WRITE, 5'h06, `PCCR_ADDR_EXT_CTRL, 16'h0001, rd);
		rdc(`PCCR_ADDR_EXT_CTRL, 16'h0004, "other address");
		chk("halt stop", 16'(n_sc), 16'h18);
		srst_in <= 1'b1;
		strap_self_run_in <= 1'b0;
		strap_master_in <= 1'b0;
		repeat (8) @(posedge core_clk_in);
		srst_in <= 1'b0;
		@(posedge core_clk_in) #1;
		chk("strap", 16'({link_enable_out, master_role_out}), 16'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
